// ### hw/smbus_line_sync.sv
// Two-flop synchronisers and edge detection for the bus lines
`timescale 1ns/1ps
module smbus_line_sync (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic [1:0] lines_in,
  output logic [1:0] lvl_out,
  output logic [1:0] rise_out,
  output logic [1:0] fall_out
);
  // ---------------------------------------------------------------
  // Per-line synchroniser
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_line
      logic meta_reg;
      logic sync_reg;
      logic prev_reg;
      // Reset to high: an idle bus floats high
      always_ff @(posedge mclk_in)
      begin
        if (srst_in)
        begin
          meta_reg <= 1'b1;
          sync_reg <= 1'b1;
          prev_reg <= 1'b1;
        end
        else if (ce_in)
        begin
          meta_reg <= lines_in[i];
          sync_reg <= meta_reg;
          prev_reg <= sync_reg;
        end
      end
      // Edges only from the settled stages
      assign lvl_out[i] = sync_reg;
      assign rise_out[i] = sync_reg & ~prev_reg;
      assign fall_out[i] = ~sync_reg & prev_reg;
    end
  endgenerate
endmodule

// ### hw/smbus_seq_pkg.sv
// Constants, encodings and timing for the two-wire status sequencer
//
// How it works
// RQ1 - Slave receiver mode ends when a STOP is seen on the bus.
// RQ2 - A data write during an active slave receive switches to slave transmit.
// RQ3 - Byte interrupt comes before the ack slot without hw ack, after it with.
// RQ4 - Vector 1110 reports START done; software loads address, next 1100.
// RQ5 - Start request while at 1110 makes a fresh START, 1110 again.
// RQ6 - Vector 1100 with ack 0 is a NACKed byte; stop aborts, both restart.
// RQ7 - Vector 1100 with ack 1 is an ACKed byte; next byte gives 1100.
// RQ8 - Stop alone ends with STOP; start and stop give STOP then START.
// RQ9 - Start alone after a sent byte makes a repeated START, vector 1110.
// RQ10 - Clearing the flag without a data write enters master receive, 1000.
// RQ11 - With hw ack, 1000 and ack 1 is an ACKed received byte.
// RQ12 - Software clears ack before release to NACK the final byte.
// RQ13 - After the last byte stop, or stop with start giving 1110.
// RQ14 - Data write before flag release turns receive into transmit, 1100.
// RQ15 - Without hw ack, 1000 with ack request set awaits software's ack bit.
// RQ16 - Start alone in master receive gives repeated START, vector 1110.
// RQ17 - Software touches the data byte only while the interrupt flag is set; the code loads a data write at any time.
// RQ18 - Shifting is MSB first; first received bit lands in the top bit.
// RQ19 - Bus is held, SCL low, until the flag clears; then settings apply.
package smbus_seq_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_STAT = 5'h04;
  localparam logic [4:0] ADDR_DATA = 5'h08;
  localparam logic [4:0] ADDR_OWN = 5'h0C;
  localparam logic [4:0] ADDR_INT_STS = 5'h10;
  localparam logic [4:0] ADDR_INT_CLR = 5'h14;
  localparam logic [4:0] ADDR_INT_EN = 5'h18;
  // Control bit positions
  localparam int CTRL_SI = 0;
  localparam int CTRL_ACK = 1;
  localparam int CTRL_STA = 2;
  localparam int CTRL_STO = 3;
  localparam int CTRL_HWACK = 4;
  localparam int CTRL_EN = 5;
  // Interrupt status bit positions
  localparam int INT_BYTE = 0;
  localparam int INT_STOP = 1;
  localparam int INT_ARB = 2;
  // Reset values
  localparam logic [6:0] OWN_ADDR_RST = 7'h3A;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [2:0] INT_RST = 3'h0;
  // ---------------------------------------------------------------
  // Status vectors
  // ---------------------------------------------------------------
  localparam logic [3:0] VEC_IDLE = 4'h0;
  localparam logic [3:0] VEC_MSTART = 4'hE;
  localparam logic [3:0] VEC_MTX = 4'hC;
  localparam logic [3:0] VEC_MRX = 4'h8;
  localparam logic [3:0] VEC_SRX = 4'h2;
  localparam logic [3:0] VEC_STX = 4'h4;
  // ---------------------------------------------------------------
  // Bit timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 20;
  localparam int SCL_PHASE_NS = 4700;
  localparam logic [8:0] PHASE_CYC = 9'((SCL_PHASE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_PRE = 4'hF;
  // Master sequencing states, Gray in declaration order
  typedef enum logic [2:0] {
    M_IDLE = 3'h0,
    M_START = 3'h1,
    M_HOLD = 3'h3,
    M_BIT_LOW = 3'h2,
    M_BIT_HIGH = 3'h6,
    M_STOP_A = 3'h7,
    M_STOP_B = 3'h5,
    M_RESTART = 3'h4
  } mst_state_t;
endpackage

// ### hw/smbus_status_sequencer.sv
// Status-vector driven two-wire master/slave sequencer with APB registers
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module smbus_status_sequencer (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [4:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic irq_out
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  smbus_seq_pkg::mst_state_t state_reg, state_next;
  logic [3:0] bitn_reg, bitn_next;
  logic tx_reg, tx_next;
  logic rs_reg, rs_next;
  logic [8:0] tmr_reg;
  logic [7:0] shift_reg;
  logic [6:0] own_reg;
  logic [3:0] vec_reg;
  logic [2:0] int_sts_reg, int_en_reg;
  logic [31:0] prdata_reg;
  logic si_reg, ack_reg, sta_reg, sto_reg, hwack_reg, en_reg;
  logic ack_request_flag_reg, arb_reg, data_wr_reg;
  logic listen_reg, addr_ph_reg, match_reg, slv_active_reg, slv_tx_reg;
  logic [3:0] bits_reg;
  logic scl_oe_reg, sda_oe_reg;
  logic [1:0] lvl, rise, fall;

  // Bus lines synchronised before any use
  smbus_line_sync u_sync (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .lines_in({sda_in, scl_in}),
    .lvl_out(lvl),
    .rise_out(rise),
    .fall_out(fall)
  );
  wire scl_lvl = lvl[0];
  wire sda_lvl = lvl[1];
  wire start_det = fall[1] & scl_lvl;
  wire stop_det = rise[1] & scl_lvl;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  wire apb_setup = psel_in & ~penable_in;
  wire apb_acc = psel_in & penable_in;
  wire hit_ctrl = paddr_in == smbus_seq_pkg::ADDR_CTRL;
  wire hit_stat = paddr_in == smbus_seq_pkg::ADDR_STAT;
  wire hit_data = paddr_in == smbus_seq_pkg::ADDR_DATA;
  wire hit_own = paddr_in == smbus_seq_pkg::ADDR_OWN;
  wire hit_ists = paddr_in == smbus_seq_pkg::ADDR_INT_STS;
  wire hit_iclr = paddr_in == smbus_seq_pkg::ADDR_INT_CLR;
  wire hit_ien = paddr_in == smbus_seq_pkg::ADDR_INT_EN;
  wire mapped = hit_ctrl | hit_stat | hit_data | hit_own | hit_ists | hit_iclr | hit_ien;
  wire apb_wr = apb_acc & pwrite_in;
  wire wr_ctrl = apb_wr & hit_ctrl;
  wire wr_data = apb_wr & hit_data;
  wire si_clr = wr_ctrl & ~pwdata_in[smbus_seq_pkg::CTRL_SI];
  wire [2:0] int_clr = (apb_wr & hit_iclr) ? pwdata_in[2:0] : 3'h0;
  wire [31:0] ctrl_rd = {26'h0, en_reg, hwack_reg, sto_reg, sta_reg, ack_reg, si_reg};
  wire [31:0] stat_rd = {24'h0, slv_tx_reg, slv_active_reg, arb_reg, ack_request_flag_reg, vec_reg};
  // Write-only clear register reads as zero
  wire [31:0] rd_mux = hit_ctrl ? ctrl_rd :
                       hit_stat ? stat_rd :
                       hit_data ? {24'h0, shift_reg} :
                       hit_own ? {25'h0, own_reg} :
                       hit_ists ? {29'h0, int_sts_reg} :
                       hit_ien ? {29'h0, int_en_reg} : 32'h0;
  // Zero wait states; read data captured in the setup cycle
  assign pready_out = 1'b1;
  assign pslverr_out = apb_acc & ~mapped;
  assign prdata_out = prdata_reg;

  // ---------------------------------------------------------------
  // Master event decode
  // ---------------------------------------------------------------
  wire tmr_done = tmr_reg == 9'h000;
  wire st_idle = state_reg == smbus_seq_pkg::M_IDLE;
  wire st_hold = state_reg == smbus_seq_pkg::M_HOLD;
  wire st_bh = state_reg == smbus_seq_pkg::M_BIT_HIGH;
  wire st_sb = state_reg == smbus_seq_pkg::M_STOP_B;
  wire mst_active = ~st_idle;
  wire bh_done = st_bh & tmr_done & scl_lvl;
  wire data_bit = bitn_reg < smbus_seq_pkg::BIT_ACK;
  wire arb_hit = bh_done & data_bit & tx_reg & shift_reg[7] & ~sda_lvl;
  // RQ3 early interrupt
  wire byte_end = bh_done & (bitn_reg == 4'h7) & ~tx_reg & ~hwack_reg;
  wire ack_end = bh_done & (bitn_reg == smbus_seq_pkg::BIT_ACK);
  wire start_end = (state_reg == smbus_seq_pkg::M_START) & tmr_done;
  wire hold_go = st_hold & ~si_reg;
  // RQ3 RQ7 RQ11 late interrupt when transmitting or when hardware acks
  wire mst_si = start_end | arb_hit | byte_end | (ack_end & (tx_reg | hwack_reg));
  wire [3:0] mst_vec = start_end ? smbus_seq_pkg::VEC_MSTART :
                       tx_reg ? smbus_seq_pkg::VEC_MTX : smbus_seq_pkg::VEC_MRX;
  // Drive levels per state; ack slot drives low for ACK when receiving
  wire bit_drv = data_bit ? (tx_reg & ~shift_reg[7]) : (~tx_reg & ack_reg);
  wire mst_scl = (state_reg == smbus_seq_pkg::M_HOLD) |
                 (state_reg == smbus_seq_pkg::M_BIT_LOW) |
                 (state_reg == smbus_seq_pkg::M_STOP_A) |
                 (state_reg == smbus_seq_pkg::M_RESTART);
  wire mst_sda = (state_reg == smbus_seq_pkg::M_START) |
                 (state_reg == smbus_seq_pkg::M_STOP_A) | (st_sb & ~rs_reg) |
                 (((state_reg == smbus_seq_pkg::M_BIT_LOW) | st_bh) & bit_drv);

  // ---------------------------------------------------------------
  // Slave event decode
  // ---------------------------------------------------------------
  wire slv_on = listen_reg & ~mst_active;
  wire slv_fall = fall[0] & slv_on;
  wire slv_rise = rise[0] & slv_on;
  wire slv_bit = bits_reg < smbus_seq_pkg::BIT_ACK;
  wire slv_ack = bits_reg == smbus_seq_pkg::BIT_ACK;
  wire match_now = (shift_reg[7:1] == own_reg) & ~shift_reg[0];
  wire ack_ok = addr_ph_reg ? (match_reg & (hwack_reg | ack_reg)) : ack_reg;
  wire slv_byte_si = slv_fall & (bits_reg == 4'h7) & ~slv_tx_reg & ~hwack_reg &
                     (~addr_ph_reg | match_now);
  wire slv_ack_si = slv_fall & slv_ack & (slv_tx_reg | (hwack_reg & ack_ok));
  wire slv_sda = slv_on & (slv_ack ? (~slv_tx_reg & ack_ok & (hwack_reg | ~si_reg)) :
                           (slv_tx_reg & slv_bit & ~shift_reg[7]));
  // RQ19 stretch while software owns the flag
  wire slv_scl = slv_on & si_reg;
  wire si_set = mst_si | slv_byte_si | slv_ack_si;

  // ---------------------------------------------------------------
  // Master next state
  // ---------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    bitn_next = bitn_reg;
    tx_next = tx_reg;
    rs_next = rs_reg;
    case (state_reg)
      smbus_seq_pkg::M_IDLE:
        if (en_reg & sta_reg & ~si_reg & scl_lvl & sda_lvl & ~listen_reg)
          state_next = smbus_seq_pkg::M_START;
      smbus_seq_pkg::M_START:
        if (tmr_done)
          state_next = smbus_seq_pkg::M_HOLD;
      smbus_seq_pkg::M_HOLD:
        if (~si_reg)
        begin
          // RQ15 software ack bit sent in the pending slot
          if (ack_request_flag_reg)
          begin
            state_next = smbus_seq_pkg::M_BIT_LOW;
            bitn_next = smbus_seq_pkg::BIT_ACK;
            tx_next = 1'b0;
          end
          // RQ8 RQ13 stop first; a kept start request restarts from idle
          else if (sto_reg)
          begin
            state_next = smbus_seq_pkg::M_STOP_A;
            rs_next = 1'b0;
          end
          // RQ9 RQ16 RQ5 repeated start from any held state
          else if (sta_reg)
          begin
            state_next = smbus_seq_pkg::M_RESTART;
            rs_next = 1'b1;
          end
          // RQ14 a fresh data write means transmit, else receive
          else
          begin
            state_next = smbus_seq_pkg::M_BIT_LOW;
            bitn_next = 4'h0;
            tx_next = data_wr_reg;
          end
        end
      smbus_seq_pkg::M_BIT_LOW:
        if (tmr_done)
          state_next = smbus_seq_pkg::M_BIT_HIGH;
      smbus_seq_pkg::M_BIT_HIGH:
        if (arb_hit)
          state_next = smbus_seq_pkg::M_IDLE;
        else if (ack_end | byte_end)
          state_next = smbus_seq_pkg::M_HOLD;
        else if (bh_done)
        begin
          state_next = smbus_seq_pkg::M_BIT_LOW;
          bitn_next = bitn_reg + 4'h1;
        end
      smbus_seq_pkg::M_STOP_A, smbus_seq_pkg::M_RESTART:
        if (tmr_done)
          state_next = smbus_seq_pkg::M_STOP_B;
      smbus_seq_pkg::M_STOP_B:
        if (tmr_done & scl_lvl)
          state_next = rs_reg ? smbus_seq_pkg::M_START : smbus_seq_pkg::M_IDLE;
      default:
        state_next = smbus_seq_pkg::M_IDLE;
    endcase
  end

  // Master registers and phase timer; high phases wait out stretching
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      state_reg <= smbus_seq_pkg::M_IDLE;
      bitn_reg <= 4'h0;
      tx_reg <= 1'b0;
      rs_reg <= 1'b0;
      tmr_reg <= smbus_seq_pkg::PHASE_CYC;
    end
    else if (ce_in)
    begin
      state_reg <= state_next;
      bitn_reg <= bitn_next;
      tx_reg <= tx_next;
      rs_reg <= rs_next;
      if ((state_next != state_reg) | ((st_bh | st_sb) & ~scl_lvl))
        tmr_reg <= smbus_seq_pkg::PHASE_CYC;
      else if (~tmr_done)
        tmr_reg <= tmr_reg - 9'h001;
    end
  end

  // ---------------------------------------------------------------
  // Control, flag and data registers
  // ---------------------------------------------------------------
  wire sta_hw_clr = (st_idle & state_next == smbus_seq_pkg::M_START) |
                    (hold_go & state_next == smbus_seq_pkg::M_RESTART);
  wire sto_hw_clr = st_sb & ~rs_reg & tmr_done & scl_lvl;
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      {en_reg, hwack_reg, sto_reg, sta_reg, ack_reg} <= 5'h00;
      si_reg <= 1'b0;
      vec_reg <= smbus_seq_pkg::VEC_IDLE;
      ack_request_flag_reg <= 1'b0;
      arb_reg <= 1'b0;
      data_wr_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      // Set wins over a clear in the same cycle
      si_reg <= si_set | (si_reg & ~si_clr);
      if (si_set)
        vec_reg <= mst_si ? mst_vec : (slv_tx_reg ? smbus_seq_pkg::VEC_STX :
                                       smbus_seq_pkg::VEC_SRX);
      if (wr_ctrl)
      begin
        en_reg <= pwdata_in[smbus_seq_pkg::CTRL_EN];
        hwack_reg <= pwdata_in[smbus_seq_pkg::CTRL_HWACK];
        sto_reg <= pwdata_in[smbus_seq_pkg::CTRL_STO];
        sta_reg <= pwdata_in[smbus_seq_pkg::CTRL_STA];
        ack_reg <= pwdata_in[smbus_seq_pkg::CTRL_ACK];
      end
      else
      begin
        sta_reg <= sta_reg & ~sta_hw_clr;
        sto_reg <= sto_reg & ~sto_hw_clr;
        // RQ6 received ack level captured for transmitted bytes
        if ((ack_end & tx_reg) | (slv_rise & slv_ack & slv_tx_reg))
          ack_reg <= ~sda_lvl;
      end
      ack_request_flag_reg <= byte_end | slv_byte_si |
                   (ack_request_flag_reg & ~(hold_go | (slv_fall & slv_ack)));
      arb_reg <= arb_hit | (arb_reg & ~si_clr);
      data_wr_reg <= wr_data | (data_wr_reg & ~(hold_go & ~ack_request_flag_reg));
    end
  end

  // RQ18 shared shift register, MSB first in and out
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      shift_reg <= smbus_seq_pkg::DATA_RST;
    else if (ce_in)
    begin
      if (wr_data)
        shift_reg <= pwdata_in[7:0];
      else if ((bh_done & data_bit) | (slv_rise & slv_bit))
        shift_reg <= {shift_reg[6:0], sda_lvl};
    end
  end

  // ---------------------------------------------------------------
  // Slave receiver and transmitter tracking
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      {listen_reg, addr_ph_reg, match_reg, slv_active_reg, slv_tx_reg} <= 5'h00;
      bits_reg <= smbus_seq_pkg::BIT_PRE;
    end
    else if (ce_in)
    begin
      // RQ1 stop ends any slave role
      if (stop_det)
        {listen_reg, slv_active_reg, slv_tx_reg} <= 3'h0;
      else if (start_det & ~mst_active & en_reg)
      begin
        {listen_reg, addr_ph_reg} <= 2'h3;
        {slv_active_reg, slv_tx_reg} <= 2'h0;
        bits_reg <= smbus_seq_pkg::BIT_PRE;
      end
      else
      begin
        // RQ2 data write while receiving turns to transmit
        if (wr_data & slv_active_reg)
          slv_tx_reg <= 1'b1;
        if (slv_fall)
        begin
          bits_reg <= slv_ack ? 4'h0 : bits_reg + 4'h1;
          if (bits_reg == 4'h7)
            match_reg <= match_now;
          if (slv_ack & addr_ph_reg)
          begin
            addr_ph_reg <= 1'b0;
            listen_reg <= ack_ok;
            slv_active_reg <= ack_ok;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Own address, interrupts, read data and pin enables
  // ---------------------------------------------------------------
  wire [2:0] int_ev = {arb_hit, stop_det, si_set};
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      own_reg <= smbus_seq_pkg::OWN_ADDR_RST;
      int_sts_reg <= smbus_seq_pkg::INT_RST;
      int_en_reg <= smbus_seq_pkg::INT_RST;
      prdata_reg <= 32'h0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      if (apb_wr & hit_own)
        own_reg <= pwdata_in[6:0];
      if (apb_wr & hit_ien)
        int_en_reg <= pwdata_in[2:0];
      int_sts_reg <= int_ev | (int_sts_reg & ~int_clr);
      if (apb_setup & ~pwrite_in)
        prdata_reg <= rd_mux;
      scl_oe_reg <= mst_scl | slv_scl;
      // Data waits a cycle while the clock is being pulled low, so a data
      // change never lands on a falling clock and fakes a START or STOP
      if (scl_oe_reg | ~(mst_scl | slv_scl))
        sda_oe_reg <= mst_sda | slv_sda;
    end
  end
  // Open drain: pins only ever pulled low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_out = scl_oe_reg;
  assign sda_oe_out = sda_oe_reg;
  assign irq_out = |(int_sts_reg & int_en_reg);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (srst_in || !ce_in);

  a_stop_exit_slave: assert property (stop_det |=> !listen_reg && !slv_tx_reg) // RQ1
    else $error("slave role kept after stop");
  a_write_to_tx: assert property (wr_data && slv_active_reg && !stop_det |=> slv_tx_reg) // RQ2
    else $error("no switch to slave transmit");
  a_early_ack_request_flag: assert property (byte_end |=> si_reg && ack_request_flag_reg && st_hold) // RQ3
    else $error("ack request missing before ack slot");
  a_start_vector: assert property (start_end |=> si_reg && vec_reg == 4'hE) // RQ4
    else $error("start vector wrong");
  a_hold_while_si: assert property (st_hold && si_reg |=> st_hold && $stable(bitn_reg)) // RQ19
    else $error("bus released with flag set");
  a_stop_path: assert property (hold_go && sto_reg && !ack_request_flag_reg
    |=> state_reg == smbus_seq_pkg::M_STOP_A ##1 scl_oe_reg && sda_oe_reg) // RQ8
    else $error("stop not issued");
  a_restart_path: assert property (hold_go && sta_reg && !sto_reg && !ack_request_flag_reg
    |=> state_reg == smbus_seq_pkg::M_RESTART && rs_reg && !sta_reg) // RQ9
    else $error("repeated start not issued");
  a_rx_vector: assert property (ack_end && !tx_reg && hwack_reg |=> vec_reg == 4'h8) // RQ10
    else $error("receive vector wrong");
  a_msb_first: assert property (bh_done && data_bit && !wr_data
    |=> shift_reg[0] == $past(sda_lvl) && shift_reg[7:1] == $past(shift_reg[6:0])) // RQ18
    else $error("shift order wrong");
endmodule

// ### tb/smbus_slave_model.sv
// Two-wire slave model: acks its address, records bytes, serves a fixed byte
`timescale 1ns/1ps
module smbus_slave_model #(
  parameter logic [6:0] ADDR = 7'h51,
  parameter logic [7:0] TXB = 8'hC5
) (
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_out,
  output logic [7:0] last_out,
  output logic mack_out
);
  int cnt = 0;
  logic adr = 1'h0;
  logic rd = 1'h0;
  logic hit = 1'h0;
  logic go = 1'h0;
  logic [7:0] sh = 8'h00;
  initial
  begin
    sda_oe_out = 1'h0;
    last_out = 8'h00;
    mack_out = 1'h0;
  end
  // Data edge while the clock is high frames the transfer
  always @(sda_in)
  begin
    if (scl_in === 1'h1)
    begin
      cnt = 0;
      adr = !sda_in;
      hit = 1'h0;
    end
  end
  // Bits arrive MSB first; the ninth rise carries the other side's ack
  always @(posedge scl_in)
  begin
    if (cnt < 8)
      sh = {sh[6:0], sda_in};
    else
      mack_out = !sda_in;
    cnt = cnt + 1;
  end
  // Drive only while the clock is low, so no false framing edge appears
  always @(negedge scl_in)
  begin
    if (cnt == 9)
    begin
      go = adr ? hit : mack_out;
      cnt = 0;
      adr = 1'h0;
    end
    if (cnt == 8)
      last_out = sh;
    if (cnt == 8 && adr)
      hit = (sh[7:1] == ADDR);
    if (cnt == 8 && adr)
      rd = sh[0];
    if (cnt == 8)
      sda_oe_out <= hit && (adr || !rd);
    else
      sda_oe_out <= hit && rd && !adr && go && cnt < 8 && !TXB[7 - cnt];
  end
endmodule

// ### tb/test_smbus_status_sequencer.sv
// Bench: master transmit, receive and interrupt paths against a slave model
`timescale 1ns/1ps
module test_smbus_status_sequencer;
  localparam logic [4:0] CTRL = smbus_seq_pkg::ADDR_CTRL;
  localparam logic [4:0] STAT = smbus_seq_pkg::ADDR_STAT;
  localparam logic [4:0] DATA = smbus_seq_pkg::ADDR_DATA;
  localparam logic [4:0] ICLR = smbus_seq_pkg::ADDR_INT_CLR;
  localparam logic [6:0] SLV = 7'h51;
  localparam logic [7:0] TXB = 8'hC5;
  logic mclk_in = 1'h0;
  logic srst_in = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [4:0] paddr = 5'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rv;
  logic pready, pslverr, err, scl_oe, sda_oe, s_oe, irq, mack;
  logic [7:0] last;
  // Open-drain lines with pull-ups
  wire scl = !scl_oe;
  wire sda = !(sda_oe || s_oe);
  int miscompares = 0;
  int checks = 0;
  smbus_status_sequencer i_dut (
    .mclk_in(mclk_in), .srst_in(srst_in), .ce_in(1'h1), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .scl_in(scl),
    .scl_out(), .scl_oe_out(scl_oe), .sda_in(sda), .sda_out(), .sda_oe_out(sda_oe),
    .irq_out(irq)
  );
  smbus_slave_model #(.ADDR(SLV), .TXB(TXB)) i_slave (
    .scl_in(scl), .sda_in(sda), .sda_oe_out(s_oe), .last_out(last), .mack_out(mack)
  );
  initial
  begin
    forever #10 mclk_in = ~mclk_in;
  end
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'h1;
    do @(posedge mclk_in); while (pready !== 1'h1);
    rv = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Bounded polling, so a dead bus cannot hang the run
  task automatic poll(input logic [4:0] a, input int b);
    int n;
    n = 0;
    rv = 32'h0;
    while (rv[b] !== 1'h1 && n < 5000)
    begin
      apb(1'h0, a, 32'h0);
      n++;
    end
    chk({31'h0, rv[b]}, 32'h1);
  endtask
  task automatic expect_si(input logic [3:0] v, input logic a, input logic ck);
    poll(CTRL, 0);
    if (ck)
      chk({31'h0, rv[1]}, {31'h0, a});
    chk({31'h0, scl}, 32'h0);
    apb(1'h0, STAT, 32'h0);
    chk({28'h0, rv[3:0]}, {28'h0, v});
  endtask
  task automatic t_master_tx();
    apb(1'h0, 5'h1C, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'h1, CTRL, 32'h24);
    expect_si(smbus_seq_pkg::VEC_MSTART, 1'h0, 1'h0);
    #1 chk({31'h0, irq}, 32'h0);
    apb(1'h1, smbus_seq_pkg::ADDR_INT_EN, 32'h1);
    #1 chk({31'h0, irq}, 32'h1);
    apb(1'h1, ICLR, 32'h1);
    #1 chk({31'h0, irq}, 32'h0);
    apb(1'h1, CTRL, 32'h24);
    expect_si(smbus_seq_pkg::VEC_MSTART, 1'h0, 1'h0);
    apb(1'h1, DATA, {24'h0, SLV, 1'h0});
    apb(1'h1, CTRL, 32'h20);
    expect_si(smbus_seq_pkg::VEC_MTX, 1'h1, 1'h1);
    apb(1'h1, DATA, 32'h96);
    apb(1'h1, CTRL, 32'h20);
    expect_si(smbus_seq_pkg::VEC_MTX, 1'h1, 1'h1);
    chk({24'h0, last}, 32'h96);
    apb(1'h1, CTRL, 32'h24);
    expect_si(smbus_seq_pkg::VEC_MSTART, 1'h0, 1'h0);
    apb(1'h1, DATA, {24'h0, SLV ^ 7'h01, 1'h0});
    apb(1'h1, CTRL, 32'h20);
    expect_si(smbus_seq_pkg::VEC_MTX, 1'h0, 1'h1);
    apb(1'h1, ICLR, 32'h2);
    apb(1'h1, CTRL, 32'h2C);
    expect_si(smbus_seq_pkg::VEC_MSTART, 1'h0, 1'h0);
    poll(smbus_seq_pkg::ADDR_INT_STS, 1);
  endtask
  task automatic t_master_rx();
    apb(1'h1, DATA, {24'h0, SLV, 1'h1});
    apb(1'h1, CTRL, 32'h30);
    expect_si(smbus_seq_pkg::VEC_MTX, 1'h1, 1'h1);
    apb(1'h1, CTRL, 32'h32);
    expect_si(smbus_seq_pkg::VEC_MRX, 1'h1, 1'h1);
    chk({31'h0, mack}, 32'h1);
    apb(1'h0, DATA, 32'h0);
    chk(rv, {24'h0, TXB});
    apb(1'h1, CTRL, 32'h22);
    expect_si(smbus_seq_pkg::VEC_MRX, 1'h1, 1'h1);
    chk({31'h0, rv[4]}, 32'h1);
    apb(1'h0, DATA, 32'h0);
    chk(rv, {24'h0, TXB});
    apb(1'h1, CTRL, 32'h22);
    apb(1'h1, CTRL, 32'h30);
    expect_si(smbus_seq_pkg::VEC_MRX, 1'h0, 1'h1);
    chk({31'h0, mack}, 32'h0);
    apb(1'h1, ICLR, 32'h2);
    apb(1'h1, CTRL, 32'h38);
    poll(smbus_seq_pkg::ADDR_INT_STS, 1);
    chk({30'h0, scl, sda}, 32'h3);
  endtask
  // Hang guard, well beyond the expected bus time
  initial
  begin
    #2000000;
    miscompares++;
    finish_test();
  end
  initial
  begin
    repeat (12) @(posedge mclk_in);
    srst_in <= 1'h0;
    t_master_tx();
    t_master_rx();
    finish_test();
  end
endmodule
